//--- logic/disch_prot_pkg.sv
// constants for the discharge protection configuration register
// How it works
// - overcurrent disable bit low: a timed overcurrent switches the pack off
// - overcurrent disable bit high: no automatic switch-off on overcurrent
// - overcurrent always sets its flag and powers the temp sensor supply
// - bits 6:5 pick overcurrent threshold 0.10, 0.12, 0.14, 0.16 V
// - short disable bit low: a timed short circuit switches the pack off
// - short disable bit high: no automatic switch-off on short circuit
// - short circuit always sets its flag and powers the temp sensor supply
// - bits 3:2 pick short threshold 0.20, 0.35, 0.65, 1.20 V
// - divide low: bits 1:0 pick 160, 320, 640, 1280 ms delay
// - divide high: bits 1:0 pick 2.5, 5, 8, 16 ms delay
// - register keeps its contents through sleep on backup power
// - discharge switch enable cleared on either fault unless disabled
// - short must last 100 us, or 10 ms with long delay set
package disch_prot_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] cfg_addr      = 8'h05;
  localparam logic [7:0] cfg_reset     = 8'h00;
  localparam int         oc_dis_bit    = 7;
  localparam int         oc_thr_lsb    = 5;
  localparam int         sc_dis_bit    = 4;
  localparam int         sc_thr_lsb    = 2;
  localparam int         oc_dly_lsb    = 0;

  // ==========================================================
  // timing
  localparam int         clk_khz       = 20000;
  localparam int         cnt_w         = 26;
  // delays in microseconds, index = delay code, +4 when divided
  localparam int         oc_delay_us [8] = '{160000, 320000, 640000,
                                             1280000, 2500, 5000, 8000,
                                             16000};
  localparam int         sc_short_us   = 100;
  localparam int         sc_long_us    = 10000;
  localparam int         sc_short_cyc  = sc_short_us * clk_khz / 1000;
  localparam int         sc_long_cyc   = sc_long_us * clk_khz / 1000;

  function automatic logic [cnt_w-1:0] us_to_cyc(input int us);
    us_to_cyc = cnt_w'(longint'(us) * clk_khz / 1000);
  endfunction

endpackage

//--- logic/discharge_protect_config.sv
// discharge protection configuration register and fault responses
`timescale 1ns/1ps
module discharge_protect_config #(
  parameter int oc_cyc_0 = disch_prot_pkg::oc_delay_us[0] / 1000
                           * (disch_prot_pkg::clk_khz),
  parameter int oc_cyc_1 = disch_prot_pkg::oc_delay_us[1] / 1000
                           * (disch_prot_pkg::clk_khz),
  parameter int oc_cyc_2 = disch_prot_pkg::oc_delay_us[2] / 1000
                           * (disch_prot_pkg::clk_khz),
  parameter int oc_cyc_3 = disch_prot_pkg::oc_delay_us[3] / 1000
                           * (disch_prot_pkg::clk_khz),
  parameter int oc_cyc_4 = disch_prot_pkg::oc_delay_us[4]
                           * disch_prot_pkg::clk_khz / 1000,
  parameter int oc_cyc_5 = disch_prot_pkg::oc_delay_us[5]
                           * disch_prot_pkg::clk_khz / 1000,
  parameter int oc_cyc_6 = disch_prot_pkg::oc_delay_us[6]
                           * disch_prot_pkg::clk_khz / 1000,
  parameter int oc_cyc_7 = disch_prot_pkg::oc_delay_us[7]
                           * disch_prot_pkg::clk_khz / 1000,
  parameter int sc_long  = disch_prot_pkg::sc_long_cyc
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       disch_oc_detect,
  input  wire logic       short_detect,
  input  wire logic       disch_delay_divide,
  input  wire logic       short_long_delay,
  input  wire logic       disch_oc_flag_clr,
  input  wire logic       short_circuit_flag_clr,
  output logic      [1:0] disch_oc_threshold_sel,
  output logic      [1:0] short_threshold_sel,
  output logic            disch_oc_flag,
  output logic            short_circuit_flag,
  output logic            temp_sensor_supply_out,
  output logic            discharge_switch_clear
);

  // ==========================================================
  // configuration register
  // reset only by power-on; sleep has no path here so contents
  // stay on backup power
  logic [7:0] cfg_ff;
  logic [7:0] rdata_ff;
  wire        addr_hit = (reg_addr == disch_prot_pkg::cfg_addr);
  wire        cfg_we   = reg_wr && addr_hit;
  wire  [7:0] nxt_cfg  = cfg_we ? reg_wdata : cfg_ff;
  wire        rd_hit   = reg_rd && addr_hit;
  // read data drops to zero between reads so a stale byte never lingers
  wire  [7:0] nxt_rdata = rd_hit ? cfg_ff : 8'h00;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= disch_prot_pkg::cfg_reset;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ==========================================================
  // field decode
  // every 2-bit code in the byte is cut out the same way
  function automatic logic [1:0] field2(input logic [7:0] val,
                                        input int         lsb);
    field2 = val[lsb +: 2];
  endfunction

  wire       oc_auto_off_disable = cfg_ff[disch_prot_pkg::oc_dis_bit];
  wire       short_auto_off_disable = cfg_ff[disch_prot_pkg::sc_dis_bit];
  wire [1:0] disch_oc_delay_sel =
    field2(cfg_ff, disch_prot_pkg::oc_dly_lsb);

  // code goes to the analog comparator reference
  assign disch_oc_threshold_sel =
    field2(cfg_ff, disch_prot_pkg::oc_thr_lsb);
  assign short_threshold_sel =
    field2(cfg_ff, disch_prot_pkg::sc_thr_lsb);

  // ==========================================================
  // delay selection
  wire [2:0] oc_idx = {disch_delay_divide, disch_oc_delay_sel};

  // divide bit and delay code pick one of eight cycle counts
  function automatic logic [disch_prot_pkg::cnt_w-1:0] oc_limit_of(
    input logic [2:0] idx);
    case (idx)
      3'h0:    oc_limit_of = disch_prot_pkg::cnt_w'(oc_cyc_0);
      3'h1:    oc_limit_of = disch_prot_pkg::cnt_w'(oc_cyc_1);
      3'h2:    oc_limit_of = disch_prot_pkg::cnt_w'(oc_cyc_2);
      3'h3:    oc_limit_of = disch_prot_pkg::cnt_w'(oc_cyc_3);
      3'h4:    oc_limit_of = disch_prot_pkg::cnt_w'(oc_cyc_4);
      3'h5:    oc_limit_of = disch_prot_pkg::cnt_w'(oc_cyc_5);
      3'h6:    oc_limit_of = disch_prot_pkg::cnt_w'(oc_cyc_6);
      default: oc_limit_of = disch_prot_pkg::cnt_w'(oc_cyc_7);
    endcase
  endfunction

  wire [disch_prot_pkg::cnt_w-1:0] oc_limit = oc_limit_of(oc_idx);

  wire [disch_prot_pkg::cnt_w-1:0] sc_limit = short_long_delay ?
    disch_prot_pkg::cnt_w'(sc_long) :
    disch_prot_pkg::cnt_w'(disch_prot_pkg::sc_short_cyc);

  // ==========================================================
  // persistence timers
  persist_if oc_pi ();
  persist_if sc_pi ();

  assign oc_pi.cond  = disch_oc_detect;
  assign oc_pi.limit = oc_limit;
  assign sc_pi.cond  = short_detect;
  assign sc_pi.limit = sc_limit;

  persist_timer u_oc_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pt      (oc_pi)
  );

  persist_timer u_sc_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pt      (sc_pi)
  );

  // ==========================================================
  // fault events
  // a zero limit never expires, a safe parking value for a timer
  wire oc_event = oc_pi.expired;
  wire sc_event = sc_pi.expired;

  // ==========================================================
  // flags and responses
  logic oc_flag_ff;
  logic sc_flag_ff;
  logic temp_ff;
  logic sw_clr_ff;

  // set beats clear so a fault in the clearing cycle is kept
  wire nxt_oc_flag = oc_event ||
                     (oc_flag_ff && !disch_oc_flag_clr);
  wire nxt_sc_flag = sc_event ||
                     (sc_flag_ff && !short_circuit_flag_clr);
  wire nxt_temp    = nxt_oc_flag || nxt_sc_flag;
  // disable bits only mask the switch-off, never the flags
  wire oc_off_req  = oc_event && !oc_auto_off_disable;
  wire sc_off_req  = sc_event && !short_auto_off_disable;
  wire nxt_sw_clr  = oc_off_req || sc_off_req;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_flag_ff <= 1'b0;
    end else begin
      oc_flag_ff <= nxt_oc_flag;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sc_flag_ff <= 1'b0;
    end else begin
      sc_flag_ff <= nxt_sc_flag;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_ff <= 1'b0;
    end else begin
      temp_ff <= nxt_temp;
    end
  end

  // level, not pulse: the switch stays off while the fault holds
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_clr_ff <= 1'b0;
    end else begin
      sw_clr_ff <= nxt_sw_clr;
    end
  end

  // ==========================================================
  // outputs
  // all leave straight from flip-flops, no decode glitch
  assign disch_oc_flag          = oc_flag_ff;
  assign short_circuit_flag     = sc_flag_ff;
  assign temp_sensor_supply_out = temp_ff;
  assign discharge_switch_clear = sw_clr_ff;

endmodule

//--- logic/persist_if.sv
// link between a fault detector and its persistence timer
`timescale 1ns/1ps
interface persist_if;
  logic                                   cond;
  logic [disch_prot_pkg::cnt_w-1:0]       limit;
  logic                                   expired;
  modport owner (output cond, output limit, input expired);
  modport timer (input cond, input limit, output expired);
endinterface

//--- logic/persist_timer.sv
// persistence timer: expires once its condition has held for limit cycles
`timescale 1ns/1ps
module persist_timer (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  persist_if.timer  pt
);

  // ==========================================================
  // counter
  logic [disch_prot_pkg::cnt_w-1:0] cnt_ff;
  logic [disch_prot_pkg::cnt_w-1:0] nxt_cnt;
  wire                              at_limit = (cnt_ff >= pt.limit);

  // any gap in the condition restarts the wait
  assign nxt_cnt = !pt.cond ? '0 :
                   at_limit ? cnt_ff :
                   cnt_ff + 1'b1;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // limit lowered mid-count still expires at once
  assign pt.expired = pt.cond && at_limit && (pt.limit != '0);

endmodule

//--- tb/disch_prot_checker.sv
// checker: assertions on the discharge protection block
`timescale 1ns/1ps
module disch_prot_checker #(parameter int sc_long = 50) (
  input wire logic       ref_clk, rst_n, reg_wr, reg_rd,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic       disch_oc_detect, short_detect, short_long_delay,
  input wire logic       disch_oc_flag_clr, short_circuit_flag_clr,
  input wire logic       disch_delay_divide, disch_oc_flag,
  input wire logic [1:0] disch_oc_threshold_sel, short_threshold_sel,
  input wire logic       short_circuit_flag, temp_sensor_supply_out,
  input wire logic       discharge_switch_clear
);
  // ==========================================================
  // register mirror and fault run lengths
  logic [7:0]  cfg_ff;
  logic [17:0] oc_run_ff;
  logic [17:0] sc_run_ff;
  wire         cfg_wr = reg_wr && reg_addr == 8'h05;
  wire  [17:0] sc_lim = short_long_delay ? 18'(sc_long) : 18'h7d0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff    <= 8'h00;
      oc_run_ff <= 18'h0;
      sc_run_ff <= 18'h0;
    end else begin
      if (cfg_wr) cfg_ff <= reg_wdata;
      oc_run_ff <= disch_oc_detect ? oc_run_ff + 18'h1 : 18'h0;
      sc_run_ff <= short_detect ? sc_run_ff + 18'h1 : 18'h0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence oc_trip_s;
    $rose(disch_oc_flag) && !cfg_ff[7];
  endsequence
  // ==========================================================
  // assertions
  thr_write_a: assert property (cfg_wr |=>
    {disch_oc_threshold_sel, short_threshold_sel} ==
    {$past(reg_wdata[6:5]), $past(reg_wdata[3:2])}) else $error("thr");
  cfg_read_a: assert property (reg_rd && reg_addr == 8'h05 && !reg_wr
    |=> reg_rdata == cfg_ff) else $error("readback");
  temp_flags_a: assert property (temp_sensor_supply_out ==
    (disch_oc_flag || short_circuit_flag)) else $error("temp");
  oc_sticky_a: assert property (disch_oc_flag && !disch_oc_flag_clr
    |=> disch_oc_flag) else $error("oc flag lost");
  sc_sticky_a: assert property (short_circuit_flag &&
    !short_circuit_flag_clr |=> short_circuit_flag) else $error("sc flag");
  oc_off_a: assert property (oc_trip_s |->
    discharge_switch_clear) else $error("oc no off");
  sc_off_a: assert property ($rose(short_circuit_flag) && !cfg_ff[4]
    |-> discharge_switch_clear) else $error("sc no off");
  off_cause_a: assert property (discharge_switch_clear |->
    disch_oc_flag && !cfg_ff[7] || short_circuit_flag && !cfg_ff[4])
    else $error("off masked");
  sc_time_a: assert property ($rose(short_circuit_flag)
    |-> sc_run_ff >= sc_lim) else $error("sc early");
  oc_time_a: assert property ($rose(disch_oc_flag)
    |-> oc_run_ff >= 18'h5) else $error("oc early");
endmodule
bind discharge_protect_config disch_prot_checker #(.sc_long(sc_long))
  u_chk (.*);

//--- tb/host_model.sv
// host model: register writes and reads
`timescale 1ns/1ps
module host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr = 8'h00,
  output logic      [7:0] reg_wdata = 8'h00,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0
);
  // released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule

//--- tb/tb_discharge_protect_config.sv
// self-checking bench for the discharge protection block
`timescale 1ns/1ps
module tb_discharge_protect_config;
  logic       ref_clk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, c;
  logic       disch_delay_divide = 1'b0, short_long_delay = 1'b0;
  logic       disch_oc_detect = 1'b0, short_detect = 1'b0;
  logic       disch_oc_flag_clr = 1'b0, short_circuit_flag_clr = 1'b0;
  logic [1:0] disch_oc_threshold_sel, short_threshold_sel;
  logic       disch_oc_flag, short_circuit_flag, temp_sensor_supply_out;
  logic       discharge_switch_clear;
  int         mismatches = 0, compares = 0, n;
  // small limits keep the run short
  int         lim [8] = '{20, 40, 80, 160, 5, 10, 16, 32};
  // rows: divide bit, config byte
  logic [8:0] rows [8] = '{9'h000, 9'h1a5, 9'h04a, 9'h1ff, 9'h0e3,
                           9'h162, 9'h025, 9'h19c};
  always #25 ref_clk = ~ref_clk;
  discharge_protect_config #(20, 40, 80, 160, 5, 10, 16, 32, 50)
    u_discharge_protect_config (.*);
  host_model u_host_model (.*);
  task automatic chk(input string s, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_flag(input bit sc);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while ((sc ? short_circuit_flag : disch_oc_flag) !== 1'b1
               && n < 3000);
  endtask
  // clear held two edges: a set in the same edge would win
  task automatic settle;
    disch_oc_detect <= 1'b0;
    short_detect <= 1'b0;
    {disch_oc_flag_clr, short_circuit_flag_clr} <= 2'h3;
    repeat (2) @(posedge ref_clk);
    #1 {disch_oc_flag_clr, short_circuit_flag_clr} <= 2'h0;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1 u_host_model.rd(8'h05, rd);
    chk("cfg_rst", 16'h0, rd);
    u_host_model.wr(8'h06, 8'hff);
    u_host_model.rd(8'h06, rd);
    chk("unmapped", 16'h0, rd);
    for (int i = 0; i < 8; i++) begin
      c = rows[i][7:0];
      disch_delay_divide <= rows[i][8];
      u_host_model.wr(8'h05, c);
      u_host_model.rd(8'h05, rd);
      chk("cfg", c, rd);
      chk("thr", {c[6:5], c[3:2]}, {disch_oc_threshold_sel, short_threshold_sel});
      disch_oc_detect <= 1'b1;
      wait_flag(0);
      chk("oc_dly", 16'(lim[{rows[i][8], c[1:0]}] + 1), 16'(n));
      chk("oc_off", !c[7], discharge_switch_clear);
      settle;
    end
    u_host_model.wr(8'h05, 8'h00);
    short_detect <= 1'b1;
    wait_flag(1);
    chk("sc_dly", 16'h7d1, 16'(n));
    chk("sc_off", 16'h1, discharge_switch_clear);
    chk("sc_flag", 16'h1, short_circuit_flag);
    chk("temp_sc", 16'h1, temp_sensor_supply_out);
    settle;
    short_long_delay <= 1'b1;
    u_host_model.wr(8'h05, 8'h10);
    short_detect <= 1'b1;
    wait_flag(1);
    chk("sc_long", 16'h33, 16'(n));
    chk("sc_off", 16'h0, discharge_switch_clear);
    settle;
    // one low cycle restarts the overcurrent count
    disch_delay_divide <= 1'b0;
    u_host_model.wr(8'h05, 8'h00);
    disch_oc_detect <= 1'b1;
    repeat (15) @(posedge ref_clk);
    #1 disch_oc_detect <= 1'b0;
    @(posedge ref_clk);
    #1 disch_oc_detect <= 1'b1;
    wait_flag(0);
    chk("oc_gap", 16'h15, 16'(n));
    chk("temp_oc", 16'h1, temp_sensor_supply_out);
    // clear while the fault still holds: the set must win
    disch_oc_flag_clr <= 1'b1;
    @(posedge ref_clk);
    #1 chk("set_wins", 16'h1, disch_oc_flag);
    disch_oc_detect <= 1'b0;
    @(posedge ref_clk);
    #1 chk("oc_clr", 16'h0, disch_oc_flag);
    chk("temp_off", 16'h0, temp_sensor_supply_out);
    disch_oc_flag_clr <= 1'b0;
    // non-zero byte so the reset readback below means something
    u_host_model.wr(8'h05, 8'h5a);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    #1 rst_n <= 1'b1;
    chk("flag_rst", 16'h0, disch_oc_flag);
    u_host_model.rd(8'h05, rd);
    chk("cfg_rst2", 16'h0, rd);
    tally_and_finish;
  end
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish;
  end
endmodule
